// ==== src/rsc_pkg.sv ====
// ----------------------------------------------------------------------------
// Shared constants for the reset strap configuration selector
// ----------------------------------------------------------------------------
package rsc_pkg;

    // Pin counts and code widths
    localparam int unsigned GPIO_W    = 5;     // General pins that double as straps
    localparam int unsigned CODE_W    = 3;     // Configuration code width
    localparam int unsigned SLOT_N    = 7;     // Stored configuration slots

    // Field positions inside the strap vector
    localparam int unsigned CODE_LSB  = 0;     // First code strap
    localparam int unsigned CODE_MSB  = 2;     // Last code strap
    localparam int unsigned TEST_LSB  = 3;     // First strap that must sit low
    localparam int unsigned TEST_MSB  = 4;     // Second strap that must sit low

    // Code values
    localparam logic [2:0] FACTORY_CODE = 3'h7;    // Unconfigured factory state
    localparam logic [2:0] RESET_CODE   = 3'h7;    // Code shown before any capture
    localparam logic [1:0] TEST_NORMAL  = 2'h0;    // Required level of upper straps

    // Reset values of pin-side state
    localparam logic [4:0] GPIO_RESET   = 5'h00;   // Pins released during reset
    localparam logic [4:0] PULL_RESET   = 5'h1f;   // All pull-downs on during reset

    // Sequencer states, Gray along hold -> load -> run
    typedef enum logic [1:0] {
        ST_HOLD = 2'h0,
        ST_LOAD = 2'h1,
        ST_RUN  = 2'h3
    } rsc_state_t;

endpackage

// ==== src/rsc_strap_loader.sv ====
`timescale 1ns/1ps

module rsc_strap_loader
    import rsc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              resetPin_n,
    input  wire logic [GPIO_W-1:0] gpioIn,
    output logic      [GPIO_W-1:0] gpioOut,
    output logic      [GPIO_W-1:0] gpioOe,
    output logic      [GPIO_W-1:0] pullDownEn,
    input  wire logic              select_low_iface_strap,
    input  wire logic              serial_out_addr_strap,
    input  wire logic              sckIn,
    input  wire logic              sdaIn,
    output logic                   sdaOut,
    output logic                   sdaOe,
    input  wire logic              i2cDriveLow,
    output logic                   hostClk,
    output logic                   hostDataIn,
    input  wire logic [SLOT_N-1:0] slotFilled,
    input  wire logic [GPIO_W-1:0] pullDownDisable,
    input  wire logic [GPIO_W-1:0] gpioDrive,
    input  wire logic [GPIO_W-1:0] gpioDriveEn,
    input  wire logic [GPIO_W-1:0] irqPinEnable,
    input  wire logic              statusEvent,
    input  wire logic              irqAck,
    output logic [CODE_W-1:0]      cfgSlot,
    output logic                   factoryDefault,
    output logic                   cfgLoadReq,
    output logic                   ifaceIsSpi,
    output logic                   i2cAddrLsb,
    output logic                   strapFault,
    output logic                   deviceReady,
    output logic                   irqPending
);

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [GPIO_W-1:0] gpioMeta;        // First stage, read only by second
    logic [GPIO_W-1:0] gpioSync;        // Safe strap levels
    logic [3:0]        ctlMeta;         // Reset, select, address, data: stage one
    logic [3:0]        ctlSync;         // Same, stage two
    logic [1:0]        sckSync;         // Host clock two-stage sync
    logic              resetPrev;       // Delayed synced reset pin
    logic              resetRise;       // Release edge of reset pin
    logic [CODE_W-1:0] cfgCode;         // Captured configuration code
    logic              addrStrap;       // Captured address strap
    rsc_state_t        state;           // Sequencer state
    rsc_state_t        next_state;      // Next sequencer state

    // Two flops on every pin before use
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gpioMeta <= GPIO_RESET;
            gpioSync <= GPIO_RESET;
            ctlMeta  <= 4'h0;
            ctlSync  <= 4'h0;
            sckSync  <= 2'h0;
        end else begin
            gpioMeta <= gpioIn;
            gpioSync <= gpioMeta;
            ctlMeta  <= {sdaIn, serial_out_addr_strap, select_low_iface_strap, resetPin_n};
            ctlSync  <= ctlMeta;
            sckSync  <= {sckSync[0], sckIn};
        end
    end

    // Edge detector on the synced reset pin
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            resetPrev <= 1'b0;
        end else begin
            resetPrev <= ctlSync[0];
        end
    end
    assign resetRise = ctlSync[0] & ~resetPrev;

    // ------------------------------------------------------------------------
    // Strap capture at reset release
    // ------------------------------------------------------------------------
    // Code, interface and address straps taken on the release edge only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfgCode    <= RESET_CODE;
            ifaceIsSpi <= 1'b0;
            addrStrap  <= 1'b0;
            strapFault <= 1'b0;
        end else if (resetRise) begin
            cfgCode    <= gpioSync[CODE_MSB:CODE_LSB];
            ifaceIsSpi <= ctlSync[1];
            addrStrap  <= ctlSync[2];
            // Flag a board that leaves the upper straps high
            strapFault <= (gpioSync[TEST_MSB:TEST_LSB] != TEST_NORMAL);
        end
    end

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    // Next state: any low reset pin returns to hold
    always_comb begin
        next_state = state;
        if (!ctlSync[0]) begin
            next_state = ST_HOLD;
        end else begin
            unique case (state)
                ST_HOLD: begin
                    if (resetRise) begin
                        next_state = ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    next_state = ST_RUN;
                end
                ST_RUN: begin
                    next_state = ST_RUN;
                end
                default: begin
                    next_state = ST_HOLD;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= ST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // Slot choice and one-cycle load request
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfgSlot        <= RESET_CODE;
            factoryDefault <= 1'b1;
            cfgLoadReq     <= 1'b0;
        end else begin
            cfgLoadReq <= 1'b0;
            if (state == ST_LOAD) begin
                cfgSlot <= cfgCode;
                // Factory code, or an empty slot, both give factory state
                if (cfgCode == FACTORY_CODE) begin
                    factoryDefault <= 1'b1;
                end else if (!slotFilled[cfgCode]) begin
                    factoryDefault <= 1'b1;
                end else begin
                    factoryDefault <= 1'b0;
                    cfgLoadReq     <= 1'b1;
                end
            end
        end
    end

    // Ready flag tells the host registers may be reached
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            deviceReady <= 1'b0;
        end else begin
            deviceReady <= (next_state == ST_RUN);
        end
    end

    // ------------------------------------------------------------------------
    // Host interface pin sharing
    // ------------------------------------------------------------------------
    // Address bit zero only meaningful in I2C mode
    assign i2cAddrLsb = ifaceIsSpi ? 1'b0 : addrStrap;

    // Clock and data towards the serial engine; clock never driven out
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hostClk    <= 1'b0;
            hostDataIn <= 1'b0;
            sdaOe      <= 1'b0;
        end else begin
            hostClk    <= sckSync[1] & (state == ST_RUN);
            hostDataIn <= ctlSync[3] & (state == ST_RUN);
            // Open-drain SDA pull only in I2C mode
            sdaOe      <= (state == ST_RUN) & ~ifaceIsSpi & i2cDriveLow;
        end
    end
    assign sdaOut = 1'b0;

    // ------------------------------------------------------------------------
    // Interrupt pending flag
    // ------------------------------------------------------------------------
    // Status events set, acknowledge clears, set wins a tie
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irqPending <= 1'b0;
        end else if (state != ST_RUN) begin
            irqPending <= 1'b0;
        end else if (statusEvent) begin
            irqPending <= 1'b1;
        end else if (irqAck) begin
            irqPending <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // General pin drivers
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < GPIO_W; gi++) begin : g_pin
            // Pins stay released and pulled down until running
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    gpioOut[gi]    <= 1'b0;
                    gpioOe[gi]     <= 1'b0;
                    pullDownEn[gi] <= 1'b1;
                end else if (state != ST_RUN) begin
                    gpioOut[gi]    <= 1'b0;
                    gpioOe[gi]     <= 1'b0;
                    pullDownEn[gi] <= PULL_RESET[gi];
                end else begin
                    pullDownEn[gi] <= ~pullDownDisable[gi];
                    if (irqPinEnable[gi]) begin
                        gpioOut[gi] <= irqPending;
                        gpioOe[gi]  <= 1'b1;
                    end else begin
                        gpioOut[gi] <= gpioDrive[gi];
                        gpioOe[gi]  <= gpioDriveEn[gi];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_code_capture: assert property (
        resetRise |=> cfgCode == $past(gpioSync[CODE_MSB:CODE_LSB]))
        else $error("strap code not captured at release");

    a_iface_select: assert property (
        resetRise |=> ifaceIsSpi == $past(ctlSync[1]))
        else $error("interface strap not captured");

    a_strap_fault: assert property (
        resetRise && gpioSync[TEST_MSB:TEST_LSB] != TEST_NORMAL |=> strapFault)
        else $error("upper straps high but no fault");

    a_empty_fallback: assert property (
        state == ST_LOAD && (cfgCode == FACTORY_CODE || !slotFilled[cfgCode])
        |=> factoryDefault && !cfgLoadReq)
        else $error("empty slot did not fall back");

    a_slot_load: assert property (
        state == ST_LOAD && cfgCode != FACTORY_CODE && slotFilled[cfgCode]
        |=> cfgLoadReq && !factoryDefault && cfgSlot == $past(cfgCode) ##1 !cfgLoadReq)
        else $error("filled slot not loaded once");

    a_release_ready: assert property (
        resetRise && ctlSync[0] |-> ##2 deviceReady || !ctlSync[0])
        else $error("ready not raised two cycles after release");

    a_irq_pin: assert property (
        state == ST_RUN && irqPinEnable[0] && statusEvent ##1 irqPinEnable[0]
        && state == ST_RUN |=> gpioOe[0] && gpioOut[0])
        else $error("interrupt pin not driven after event");

    a_pulldown_ctl: assert property (
        state == ST_RUN ##1 state == ST_RUN |-> pullDownEn == ~$past(pullDownDisable))
        else $error("pull-down control not applied");

    a_addr_lsb: assert property (
        ifaceIsSpi |-> !i2cAddrLsb)
        else $error("address bit leaks in SPI mode");

    a_sda_mode: assert property (
        sdaOe |-> !ifaceIsSpi && $past(i2cDriveLow) && !sdaOut)
        else $error("SDA driven outside I2C mode");

endmodule

// ==== bench/rsc_host_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Host controller model: serial clock and shared data line
// ----------------------------------------------------------------------------
module rsc_host_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       startFrame,  // Begin one byte frame
    input  wire logic [7:0] frameByte,   // Byte shifted out MSB first
    input  wire logic       sdaOut,      // Device drive value
    input  wire logic       sdaOe,       // Device pull-low enable
    output logic            sckIn,       // Clock level at device pin
    output logic            sdaIn,       // Resolved data line level
    output logic            frameBusy    // Frame in progress
);
    logic [4:0] phase;     // Four cycles per bit, eight bits
    logic [7:0] shiftReg;  // Byte being sent
    logic       hostData;  // Host side data level

    // Frame sequencer; clock stands still between frames
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frameBusy <= 1'b0;
            phase     <= 5'h00;
            shiftReg  <= 8'h00;
        end else if (!frameBusy && startFrame) begin
            frameBusy <= 1'b1;
            phase     <= 5'h00;
            shiftReg  <= frameByte;
        end else if (frameBusy) begin
            phase <= phase + 5'h01;
            if (phase == 5'h1f) begin
                frameBusy <= 1'b0;
            end
        end
    end

    // Host sources the clock; idle high through the pull-up
    assign sckIn    = frameBusy ? phase[1] : 1'b1;
    // Data changes while clock is low, except the release at frame end with clock high; released level is high
    assign hostData = frameBusy ? shiftReg[3'h7 - phase[4:2]] : 1'b1;
    // Open-drain line: either party may pull it low
    assign sdaIn    = hostData & ~(sdaOe & ~sdaOut);
endmodule

// ==== bench/reset_strap_config_select_test.sv ====
`timescale 1ns/1ps

module reset_strap_config_select_test
    import rsc_pkg::*;
;
    logic              sys_clk, rst, resetPin_n, selStrap, soStrap;
    logic              i2cDriveLow, statusEvent, irqAck, startFrame;
    logic [GPIO_W-1:0] strapVal, pullDownDisable, gpioDrive, gpioDriveEn, irqPinEnable;
    logic [SLOT_N-1:0] slotFilled;   // Flash slot occupancy
    logic [7:0]        frameByte;    // Host frame payload
    wire logic [GPIO_W-1:0] gpioIn, gpioOut, gpioOe, pullDownEn;
    wire logic [CODE_W-1:0] cfgSlot;
    wire logic sckIn, sdaIn, sdaOut, sdaOe, hostClk, hostDataIn, frameBusy;
    wire logic factoryDefault, cfgLoadReq, ifaceIsSpi, i2cAddrLsb;
    wire logic strapFault, deviceReady, irqPending;
    int n_mismatch = 0;
    int check_count = 0;

    // Pin level: device drive wins, else strap source; pull-down not modelled
    assign gpioIn = (gpioOe & gpioOut) | (~gpioOe & strapVal);

    rsc_strap_loader DUT (.sys_clk(sys_clk), .rst(rst), .resetPin_n(resetPin_n),
        .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe), .pullDownEn(pullDownEn),
        .select_low_iface_strap(selStrap), .serial_out_addr_strap(soStrap),
        .sckIn(sckIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .i2cDriveLow(i2cDriveLow), .hostClk(hostClk), .hostDataIn(hostDataIn),
        .slotFilled(slotFilled), .pullDownDisable(pullDownDisable),
        .gpioDrive(gpioDrive), .gpioDriveEn(gpioDriveEn), .irqPinEnable(irqPinEnable),
        .statusEvent(statusEvent), .irqAck(irqAck), .cfgSlot(cfgSlot),
        .factoryDefault(factoryDefault), .cfgLoadReq(cfgLoadReq), .ifaceIsSpi(ifaceIsSpi),
        .i2cAddrLsb(i2cAddrLsb), .strapFault(strapFault), .deviceReady(deviceReady),
        .irqPending(irqPending));

    rsc_host_model HOST (.sys_clk(sys_clk), .rst(rst), .startFrame(startFrame),
        .frameByte(frameByte), .sdaOut(sdaOut), .sdaOe(sdaOe), .sckIn(sckIn),
        .sdaIn(sdaIn), .frameBusy(frameBusy));

    // ------------------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Reset pulse, straps held around the release, then changed
    task automatic release_strap(input logic [2:0] code, input logic [1:0] upper,
                                 input logic sel, input logic so);
        int  loads;
        logic fact;
        loads = 0;
        fact = (code == FACTORY_CODE) || !slotFilled[code];
        resetPin_n = 1'b0;
        strapVal = {upper, code};
        selStrap = sel;
        soStrap = so;
        repeat (20) @(negedge sys_clk);
        resetPin_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(negedge sys_clk);
            if (i == 4) begin
                strapVal = ~{upper, code};
                selStrap = ~sel;
                soStrap = ~so;
            end
            if (cfgLoadReq === 1'b1) loads++;
        end
        // Ready must stand before any host access; give up if it never came
        chk(deviceReady, 1'b1);
        if (deviceReady !== 1'b1) begin
            wrap_up();
        end
        chk(factoryDefault, fact);
        chk(loads, fact ? 8'h00 : 8'h01);
        if (!fact) chk(cfgSlot, code);
        chk(ifaceIsSpi, sel);
        chk(i2cAddrLsb, sel ? 1'b0 : so);
        chk(strapFault, upper != TEST_NORMAL);
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic irq_test;
        irqPinEnable = 5'h01;
        gpioDrive = 5'h04;
        gpioDriveEn = 5'h04;
        statusEvent = 1'b1;
        @(negedge sys_clk);
        statusEvent = 1'b0;
        chk(irqPending, 1'b1);
        @(negedge sys_clk);
        chk(gpioOut & gpioOe, 5'h05);
        statusEvent = 1'b1;
        irqAck = 1'b1;
        @(negedge sys_clk);
        statusEvent = 1'b0;
        chk(irqPending, 1'b1);
        @(negedge sys_clk);
        irqAck = 1'b0;
        @(negedge sys_clk);
        chk(irqPending, 1'b0);
    endtask

    task automatic pull_test;
        pullDownDisable = 5'h0a;
        repeat (2) @(negedge sys_clk);
        chk(pullDownEn, 5'h15);
        resetPin_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        statusEvent = 1'b1;
        @(negedge sys_clk);
        statusEvent = 1'b0;
        @(negedge sys_clk);
        chk(pullDownEn, 5'h1f);
        chk({irqPending, deviceReady, gpioOe}, 8'h00);
    endtask

    // Host waits for ready before using the interface
    task automatic host_test(input logic sel);
        logic [2:0] sckHist, sdaHist;
        sckHist = 3'h7;
        sdaHist = 3'h7;
        release_strap(3'h0, 2'h0, sel, 1'b0);
        i2cDriveLow = 1'b1;
        @(negedge sys_clk);
        chk({sdaOe, sdaIn}, {~sel, sel});
        i2cDriveLow = 1'b0;
        frameByte = 8'ha6;
        startFrame = 1'b1;
        @(negedge sys_clk);
        startFrame = 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(negedge sys_clk);
            if (i >= 3) chk({hostClk, hostDataIn}, {sckHist[2], sdaHist[2]});
            sckHist = {sckHist[1:0], sckIn};
            sdaHist = {sdaHist[1:0], sdaIn};
        end
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        {rst, resetPin_n, selStrap, soStrap, i2cDriveLow} = 5'h10;
        {statusEvent, irqAck, startFrame, frameByte} = 11'h000;
        {strapVal, pullDownDisable, gpioDrive, gpioDriveEn, irqPinEnable} = 25'h0;
        slotFilled = 7'h7f;
        repeat (10) @(negedge sys_clk);
        chk({pullDownEn, factoryDefault, cfgSlot}, {5'h1f, 1'b1, 3'h7});
        rst = 1'b0;
        for (int c = 0; c < 8; c++) release_strap(c[2:0], 2'h0, 1'b1, 1'b0);
        slotFilled = 7'h7b;
        release_strap(3'h2, 2'h0, 1'b0, 1'b1);
        release_strap(3'h5, 2'h2, 1'b0, 1'b0);
        irq_test();
        pull_test();
        host_test(1'b0);
        host_test(1'b1);
        wrap_up();
    end
endmodule
